// ---- src/cascaded_switch_chain_loader.sv ----
// serial loader for a daisy chain of rf path switch modules
`default_nettype none
module cascaded_switch_chain_loader
    import chain_loader_pkg::*;
#(
    parameter int unsigned NUM_MAX  = chain_loader_pkg::MAX_MODULES,
    parameter int unsigned HALF_BIT = chain_loader_pkg::HALF_BIT_CYCLES
)(
    // system clock and reset
    input  wire logic                              core_clk,
    input  wire logic                              sys_rst,
    // link clock
    input  wire logic                              link_clk,
    // path code loading, core_clk domain
    input  wire logic                              code_wr,
    input  wire logic [chain_loader_pkg::MOD_W-1:0] code_wr_module,
    input  wire logic [chain_loader_pkg::PORT_W-1:0] code_wr_port,
    // update request, core_clk domain
    input  wire logic                              update_start,
    input  wire logic [chain_loader_pkg::MOD_W-1:0] module_count,
    input  wire logic [chain_loader_pkg::BITS_W-1:0] word_bits,
    output logic                                   busy,
    output logic                                   update_done,
    output logic                                   start_refused,
    // serial link to the chain head, link_clk domain
    output logic                                   serial_clk,
    output logic                                   serial_data,
    output logic                                   latch_strobe
);
    import chain_loader_pkg::*;

    // ************************************************************
    // core domain: code table and request handshake
    // ************************************************************
    logic [CODE_W-1:0] codes_ff [1:NUM_MAX];
    logic [MOD_W-1:0]  count_ff;
    logic [BITS_W-1:0] bits_ff;
    logic              busy_ff;
    logic              req_tgl_ff;
    logic              ack_s1_ff;
    logic              ack_s2_ff;
    logic              ack_seen_ff;
    // driven by the link sequencer, declared here because the core side reads it first
    logic              ack_tgl_ff;
    logic              done_ff;
    logic              refused_ff;
    logic              code_ok;
    logic [CODE_W-1:0] nxt_code;
    logic              start_ok;

    always_comb
    begin
        code_ok  = 1'b1;
        nxt_code = CODE_RESET;
        unique case (code_wr_port)
            4'h1:    nxt_code = CODE_PORT1;
            4'h2:    nxt_code = CODE_PORT2;
            4'h3:    nxt_code = CODE_PORT3;
            4'h4:    nxt_code = CODE_PORT4;
            4'h5:    nxt_code = CODE_PORT5;
            4'h6:    nxt_code = CODE_PORT6;
            4'h7:    nxt_code = CODE_PORT7;
            4'h8:    nxt_code = CODE_PORT8;
            4'h9:    nxt_code = CODE_PORT9;
            4'hA:    nxt_code = CODE_PORT10;
            default: code_ok  = 1'b0;
        endcase
    end

    // entry one belongs to the module next to the master
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 1; i <= NUM_MAX; i++)
                codes_ff[i] <= CODE_RESET;
        end
        else if (code_wr && !busy_ff && code_ok && code_wr_module != '0
                 && code_wr_module <= MOD_W'(NUM_MAX))
        begin
            codes_ff[code_wr_module] <= nxt_code;
        end
    end

    // count must lie in one..max, word length in one..sixteen
    assign start_ok = update_start && !busy_ff && module_count != '0
                      && module_count <= MOD_W'(NUM_MAX) && word_bits != '0
                      && word_bits <= BITS_W'(MAX_BITS);

    // ack toggle from the link domain, two flops before use
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ack_s1_ff   <= 1'b0;
            ack_s2_ff   <= 1'b0;
            ack_seen_ff <= 1'b0;
        end
        else
        begin
            ack_s1_ff   <= ack_tgl_ff;
            ack_s2_ff   <= ack_s1_ff;
            ack_seen_ff <= ack_s2_ff;
        end
    end

    // config is frozen while busy, so the link side may read it directly
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            busy_ff    <= 1'b0;
            req_tgl_ff <= 1'b0;
            count_ff   <= '0;
            bits_ff    <= '0;
            done_ff    <= 1'b0;
            refused_ff <= 1'b0;
        end
        else
        begin
            done_ff    <= 1'b0;
            refused_ff <= update_start && !start_ok;
            if (start_ok)
            begin
                busy_ff    <= 1'b1;
                req_tgl_ff <= ~req_tgl_ff;
                count_ff   <= module_count;
                bits_ff    <= word_bits;
            end
            else if (busy_ff && (ack_s2_ff != ack_seen_ff))
            begin
                busy_ff <= 1'b0;
                done_ff <= 1'b1;
            end
        end
    end

    assign busy          = busy_ff;
    assign update_done   = done_ff;
    assign start_refused = refused_ff;

    // ************************************************************
    // link domain: reset release and request sync
    // ************************************************************
    logic link_rst_s1_ff;
    logic link_rst_ff;
    logic req_s1_ff;
    logic req_s2_ff;
    logic req_seen_ff;

    // reset asserts at once, releases on the link clock
    always_ff @(posedge link_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            link_rst_s1_ff <= 1'b1;
            link_rst_ff    <= 1'b1;
        end
        else
        begin
            link_rst_s1_ff <= 1'b0;
            link_rst_ff    <= link_rst_s1_ff;
        end
    end

    always_ff @(posedge link_clk or posedge link_rst_ff)
    begin
        if (link_rst_ff)
        begin
            req_s1_ff   <= 1'b0;
            req_s2_ff   <= 1'b0;
            req_seen_ff <= 1'b0;
        end
        else
        begin
            req_s1_ff   <= req_tgl_ff;
            req_s2_ff   <= req_s1_ff;
            req_seen_ff <= req_s2_ff;
        end
    end

    // ************************************************************
    // link domain: shift and latch sequencer
    // ************************************************************
    link_state_t          state_ff;
    logic [HALF_W-1:0]    half_cnt_ff;
    logic                 phase_ff;
    logic [MOD_W-1:0]     mod_idx_ff;
    logic [BIT_IDX_W-1:0] bit_idx_ff;
    logic                 half_end;
    logic [MAX_BITS-1:0]  cur_word;
    logic [BIT_IDX_W-1:0] top_bit;

    assign half_end = (half_cnt_ff == HALF_W'(HALF_BIT - 1));
    // code in the low bits, unused upper bits of a long word shift as zero
    assign cur_word = {{(MAX_BITS-CODE_W){1'b0}}, codes_ff[mod_idx_ff]};
    assign top_bit  = BIT_IDX_W'(bits_ff - 1'b1);

    always_ff @(posedge link_clk or posedge link_rst_ff)
    begin
        if (link_rst_ff)
            half_cnt_ff <= '0;
        else if (state_ff == ST_IDLE || half_end)
            half_cnt_ff <= '0;
        else
            half_cnt_ff <= half_cnt_ff + 1'b1;
    end

    always_ff @(posedge link_clk or posedge link_rst_ff)
    begin
        if (link_rst_ff)
        begin
            state_ff     <= ST_IDLE;
            phase_ff     <= 1'b0;
            mod_idx_ff   <= '0;
            bit_idx_ff   <= '0;
            ack_tgl_ff   <= 1'b0;
            serial_clk   <= 1'b0;
            serial_data  <= 1'b0;
            latch_strobe <= 1'b0;
        end
        else
        begin
            unique case (state_ff)
                ST_IDLE:
                begin
                    serial_clk <= 1'b0;
                    if (req_s2_ff != req_seen_ff)
                    begin
                        mod_idx_ff <= count_ff;
                        bit_idx_ff <= top_bit;
                        phase_ff   <= 1'b0;
                        state_ff   <= ST_SHIFT;
                    end
                end
                ST_SHIFT:
                begin
                    // msb first, data set while clock is low
                    serial_data <= cur_word[bit_idx_ff];
                    if (half_end)
                    begin
                        phase_ff   <= ~phase_ff;
                        serial_clk <= ~phase_ff;
                        if (phase_ff)
                        begin
                            if (bit_idx_ff != '0)
                                bit_idx_ff <= bit_idx_ff - 1'b1;
                            // one word per module, then the strobe
                            else if (mod_idx_ff == MOD_W'(1))
                                state_ff <= ST_LATCH;
                            else
                            begin
                                mod_idx_ff <= mod_idx_ff - 1'b1;
                                bit_idx_ff <= top_bit;
                            end
                        end
                    end
                end
                ST_LATCH:
                begin
                    // strobe high for one half bit
                    latch_strobe <= 1'b1;
                    if (half_end)
                        state_ff <= ST_SETTLE;
                end
                ST_SETTLE:
                begin
                    // strobe back low, chain holds new paths
                    latch_strobe <= 1'b0;
                    if (half_end)
                    begin
                        ack_tgl_ff <= ~ack_tgl_ff;
                        state_ff   <= ST_IDLE;
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- src/chain_loader_pkg.sv ----
// constants shared by the switch chain loader
`default_nettype none
package chain_loader_pkg;
    // chain and word geometry
    localparam int unsigned MAX_MODULES  = 50;
    localparam int unsigned MOD_W        = 6;
    localparam int unsigned MAX_BITS     = 16;
    localparam int unsigned BITS_W       = 5;
    localparam int unsigned CODE_W       = 4;
    localparam int unsigned PORT_W       = 4;
    localparam int unsigned BIT_IDX_W    = 4;

    // serial timing: bit rate and the link clock period it is derived from
    localparam longint unsigned BIT_RATE_BPS     = 330000;
    localparam longint unsigned LINK_CLK_PERIOD_PS = 12000;
    localparam longint unsigned PS_PER_S         = 64'hE8D4A51000;
    // longest half bit, rounded down so the rate never falls below nominal
    localparam longint unsigned HALF_BIT_CYC_RAW =
        PS_PER_S / (BIT_RATE_BPS * 2 * LINK_CLK_PERIOD_PS);
    localparam int unsigned HALF_BIT_CYCLES  =
        (HALF_BIT_CYC_RAW < 1) ? 1 : int'(HALF_BIT_CYC_RAW);
    localparam int unsigned HALF_W           = 12;

    // path codes per output port number
    localparam logic [CODE_W-1:0] CODE_PORT1  = 4'hA;
    localparam logic [CODE_W-1:0] CODE_PORT2  = 4'hB;
    localparam logic [CODE_W-1:0] CODE_PORT3  = 4'h9;
    localparam logic [CODE_W-1:0] CODE_PORT4  = 4'h8;
    localparam logic [CODE_W-1:0] CODE_PORT5  = 4'hC;
    localparam logic [CODE_W-1:0] CODE_PORT6  = 4'h4;
    localparam logic [CODE_W-1:0] CODE_PORT7  = 4'h2;
    localparam logic [CODE_W-1:0] CODE_PORT8  = 4'h3;
    localparam logic [CODE_W-1:0] CODE_PORT9  = 4'h1;
    localparam logic [CODE_W-1:0] CODE_PORT10 = 4'h0;
    localparam logic [CODE_W-1:0] CODE_RESET  = CODE_PORT10;

    // link sequencer states, gray along idle -> shift -> latch -> settle
    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_SHIFT  = 2'h1,
        ST_LATCH  = 2'h3,
        ST_SETTLE = 2'h2
    } link_state_t;
endpackage
`default_nettype wire

// ---- verification/loader_asserts.sv ----
// port-level checks for the switch chain loader
`default_nettype none
module loader_asserts
    import chain_loader_pkg::*;
#(
    parameter int unsigned NUM_MAX  = 50,
    parameter int unsigned HALF_BIT = HALF_BIT_CYCLES
)(
    // clocks and reset
    input wire logic                    core_clk,
    input wire logic                    sys_rst,
    input wire logic                    link_clk,
    // update request and status
    input wire logic                    update_start,
    input wire logic [MOD_W-1:0]        module_count,
    input wire logic [BITS_W-1:0]       word_bits,
    input wire logic                    busy,
    input wire logic                    update_done,
    input wire logic                    start_refused,
    // serial link
    input wire logic                    serial_clk,
    input wire logic                    serial_data,
    input wire logic                    latch_strobe
);
    // ****
    // request sequences
    // ****
    sequence s_go;
        update_start && !busy && module_count >= 1 && module_count <= NUM_MAX
            && word_bits >= 1 && word_bits <= MAX_BITS;
    endsequence
    sequence s_bad;
        update_start && !busy && (module_count == 0 || module_count > NUM_MAX
            || word_bits == 0 || word_bits > MAX_BITS);
    endsequence

    // ****
    // serial clock high-time counter
    // ****
    int unsigned hi_cnt_ff;

    // high phase length in link cycles
    always_ff @(posedge link_clk or posedge sys_rst)
    begin
        if (sys_rst)
            hi_cnt_ff <= 0;
        else if (serial_clk)
            hi_cnt_ff <= hi_cnt_ff + 1;
        else
            hi_cnt_ff <= 0;
    end

    start_taken_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_go |=> busy && !start_refused) else $error("legal start not taken");
    refuse_cfg_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_bad |=> start_refused && !busy) else $error("bad config not refused");
    refuse_busy_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        update_start && busy |=> start_refused) else $error("start while busy taken");
    done_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        update_done |=> !update_done) else $error("done longer than a cycle");
    done_drop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        update_done |-> !busy && $past(busy)) else $error("done without busy end");
    strobe_quiet_a: assert property (@(posedge link_clk) disable iff (sys_rst)
        latch_strobe |-> !serial_clk) else $error("clock runs during strobe");
    data_hold_a: assert property (@(posedge link_clk) disable iff (sys_rst)
        serial_clk |-> $stable(serial_data)) else $error("data moved while clock high");
    strobe_tail_a: assert property (@(posedge link_clk) disable iff (sys_rst)
        $fell(latch_strobe) |-> !serial_clk [*2]) else $error("clock after strobe");
    clk_high_a: assert property (@(posedge link_clk) disable iff (sys_rst)
        $fell(serial_clk) |-> hi_cnt_ff == HALF_BIT) else $error("serial clock high time wrong");
endmodule

bind cascaded_switch_chain_loader loader_asserts #(.NUM_MAX(NUM_MAX), .HALF_BIT(HALF_BIT))
    i_loader_asserts (
    .core_clk(core_clk), .sys_rst(sys_rst), .link_clk(link_clk),
    .update_start(update_start), .module_count(module_count), .word_bits(word_bits),
    .busy(busy), .update_done(update_done), .start_refused(start_refused),
    .serial_clk(serial_clk), .serial_data(serial_data), .latch_strobe(latch_strobe));
`default_nettype wire

// ---- verification/switch_chain_model.sv ----
// behavioural chain of four-bit switch modules on the far end of the link
`default_nettype none
module switch_chain_model #(
    parameter int unsigned NMOD = 50
)(
    // serial link from the master
    input  wire logic                   serial_clk,
    input  wire logic                   serial_data,
    input  wire logic                   latch_strobe,
    // applied paths, module k in bits 4k-1 down to 4k-4
    output var logic [4*NMOD-1:0]       applied,
    output var int unsigned             applies
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [4*NMOD-1:0] shift_ff  = '0;
    int unsigned       apply_cnt = 0;

    assign applies = apply_cnt;
    always @(posedge serial_clk)
        if (!latch_strobe)
            shift_ff <= {shift_ff[4*NMOD-2:0], serial_data};
    always @(posedge latch_strobe)
    begin
        applied   <= shift_ff;
        apply_cnt <= apply_cnt + 1;
    end
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// self-checking bench for the switch chain loader
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // ****
    // stimulus, model and checks
    // ****
    logic core_clk = 1'b0, link_clk = 1'b0, sys_rst, code_wr, update_start;
    logic [5:0] code_wr_module, module_count;
    logic [4:0] word_bits;
    logic [3:0] code_wr_port;
    logic busy, update_done, start_refused, serial_clk, serial_data, latch_strobe;
    logic [199:0] applied, exp_sr = '0, q[$];
    int unsigned applies, seen = 0;
    int mismatches = 0, checked = 0, cycles = 0;
    logic [3:0] codes [1:50];
    localparam logic [3:0] PCODE [1:10] = '{4'hA, 4'hB, 4'h9, 4'h8, 4'hC,
        4'h4, 4'h2, 4'h3, 4'h1, 4'h0};

    always #20 core_clk = ~core_clk;
    // unrelated phase to the core clock
    initial
    begin
        #3.3;
        forever #6 link_clk = ~link_clk;
    end

    cascaded_switch_chain_loader #(.NUM_MAX(50), .HALF_BIT(3)) i_cascaded_switch_chain_loader (
        .core_clk(core_clk), .sys_rst(sys_rst), .link_clk(link_clk), .code_wr(code_wr),
        .code_wr_module(code_wr_module), .code_wr_port(code_wr_port),
        .update_start(update_start), .module_count(module_count), .word_bits(word_bits),
        .busy(busy), .update_done(update_done), .start_refused(start_refused),
        .serial_clk(serial_clk), .serial_data(serial_data), .latch_strobe(latch_strobe));
    switch_chain_model #(.NMOD(50)) i_switch_chain_model (.serial_clk(serial_clk),
        .serial_data(serial_data), .latch_strobe(latch_strobe), .applied(applied),
        .applies(applies));

    task automatic check(input logic [199:0] got, input logic [199:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t: saw %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wr(input int m, input int p);
        @(posedge core_clk);
        code_wr <= 1'b1;
        code_wr_module <= m[5:0];
        code_wr_port <= p[3:0];
        @(posedge core_clk);
        code_wr <= 1'b0;
        // ports outside 1..10 are ignored
        if (p >= 1 && p <= 10)
            codes[m] = PCODE[p];
    endtask

    task automatic run(input int n, input int b, input bit poke);
        bit ok;
        ok = n >= 1 && n <= 50 && b >= 1 && b <= 16;
        @(posedge core_clk);
        update_start <= 1'b1;
        module_count <= n[5:0];
        word_bits <= b[4:0];
        @(posedge core_clk);
        update_start <= 1'b0;
        #1;
        check(start_refused, !ok);
        if (ok)
        begin
            for (int m = n; m >= 1; m--)
                for (int i = b - 1; i >= 0; i--)
                    exp_sr = {exp_sr[198:0], (i < 4) ? codes[m][i] : 1'b0};
            q.push_back(exp_sr);
            if (poke)
            begin
                // table is frozen while busy, so this write must not land
                @(posedge core_clk);
                update_start <= 1'b1;
                code_wr <= 1'b1;
                code_wr_module <= 6'h01;
                code_wr_port <= 4'h5;
                @(posedge core_clk);
                update_start <= 1'b0;
                code_wr <= 1'b0;
                #1;
                check(start_refused, 1'b1);
            end
            for (int k = 0; k < 4000 && update_done !== 1'b1; k++)
            begin
                @(posedge core_clk);
                #1;
            end
            check(update_done, 1'b1);
            check(latch_strobe, 1'b0);
        end
        $display("test done: %0d modules, %0d bits", n, b);
    endtask

    // the model reports each apply; oldest note is compared with it
    always @(posedge core_clk)
        if (applies != seen)
        begin
            seen = applies;
            if (q.size() == 0)
                check(applied, ~applied);
            else
                check(applied, q.pop_front());
        end

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            mismatches++;
            $display("ERROR %0t: run did not finish", $time);
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("counts: %0d checked, %0d mismatches", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        sys_rst = 1'b1;
        code_wr = 1'b0;
        update_start = 1'b0;
        code_wr_module = 6'h00;
        code_wr_port = 4'h0;
        module_count = 6'h00;
        word_bits = 5'h00;
        foreach (codes[m])
            codes[m] = 4'h0;
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (8) @(posedge core_clk);
        void'($urandom(49047));
        run(3, 4, 1'b0);
        for (int m = 1; m <= 50; m++)
            wr(m, $urandom_range(15, 0));
        run(1, 4, 1'b0);
        run(50, 4, 1'b1);
        run(50, 16, 1'b0);
        run(3, 1, 1'b0);
        run(2, 7, 1'b0);
        repeat (3)
        begin
            wr($urandom_range(50, 1), $urandom_range(15, 0));
            run($urandom_range(50, 1), $urandom_range(16, 1), 1'b0);
        end
        run(0, 4, 1'b0);
        run(51, 4, 1'b0);
        run(2, 0, 1'b0);
        run(2, 17, 1'b0);
        repeat (10) @(posedge core_clk);
        check(q.size(), 0);
        wrap_up();
    end
endmodule
`default_nettype wire
